// ### common/crc_pkg.sv
/*
 * Shared constants and carriers for the byte-fed CRC engine with
 * automatic flash sector scan.
 * Assumes an 8-bit special function register bus clocked by mclk and
 * a byte-wide flash read port owned by the same clock domain.
 */
package crc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CRC_CONTROL_ADDR    = 8'h91; // control
    localparam logic [7:0] CRC_BYTE_INPUT_ADDR = 8'h94; // data in
    localparam logic [7:0] CRC_AUTO_CTRL_ADDR  = 8'h96; // auto control
    localparam logic [7:0] CRC_SECTOR_CNT_ADDR = 8'h97; // sector count
    localparam logic [7:0] CRC_RESULT_ADDR     = 8'hd9; // result port

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_SEL_BIT    = 4;  // polynomial_select
    localparam int CTL_INIT_BIT   = 3;  // result_initialise
    localparam int CTL_VAL_BIT    = 2;  // set_value_select
    localparam int AUTO_EN_BIT    = 7;  // automatic_enable
    localparam int AUTO_CPT_BIT   = 6;  // completion_flag
    localparam int AUTO_RSVD_BIT  = 5;  // reserved, reads zero
    localparam int ST_W           = 5;  // start_sector width
    localparam int CNT_W          = 6;  // sector_count width

    // ------------------------------------------------------------
    // Polynomials, seeds, sizes, reset values
    // ------------------------------------------------------------
    localparam logic [15:0] POLY16       = 16'h1021;
    localparam logic [31:0] POLY32_REFL  = 32'hedb88320;
    localparam logic [31:0] SEED_ZEROS   = 32'h00000000;
    localparam logic [31:0] SEED_ONES    = 32'hffffffff;
    localparam int          SECTOR_SHIFT = 9;   // 512-byte sectors
    localparam int          FADDR_W      = 17;  // scan address width
    localparam int          FIFO_DEPTH   = 8;
    localparam int          FIFO_WIDTH   = 8;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic        CPT_RESET    = 1'b1;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;     // one-cycle write strobe
        logic       rd;     // one-cycle read strobe
        logic [7:0] addr;   // register address
        logic [7:0] wdata;  // write data
    } crc_sfr_req_t;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_REQ  = 2'b01,
        SCAN_WAIT = 2'b10,
        SCAN_TAIL = 2'b11
    } crc_scan_t;

endpackage

// ### src/crc_engine.sv
/*
 * CRC engine top module and its fetch FIFO.
 * Assumes register strobes and flash answers are synchronous to mclk,
 * and that the processor honours cpu_stall while a scan runs.
 */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Byte FIFO between flash fetch and CRC folding
// ----------------------------------------------------------------
module crc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,      // system clock
    input  wire logic             nrst,      // async reset, low
    input  wire logic             in_valid,  // push request
    output logic                  in_ready,  // room left
    input  wire logic [WIDTH-1:0] in_data,   // push data
    output logic                  out_valid, // data present
    input  wire logic             out_ready, // pop request
    output logic      [WIDTH-1:0] out_data   // head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];      // storage
    logic [AW-1:0]    wr_ptr_reg;       // write index
    logic [AW-1:0]    rd_ptr_reg;       // read index
    logic [AW:0]      count_reg;        // fill level
    logic             push;             // accepted write
    logic             pop;              // accepted read

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // Storage writes, no reset needed on data
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ?
                              '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ?
                              '0 : rd_ptr_reg + 1'b1;
            end
            // Simultaneous push and pop leaves the level unchanged
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Behaviour
// R1: control bits 7:5 read zero, writes ignored
// R2: select bit picks 32-bit or 16-bit polynomial
// R3: writing one to initialise loads whole result
// R4: set-value bit picks zeros or ones seed
// R5: result pointer increments after each port access
// R6: 32-bit mode maps pointer to four bytes
// R7: 16-bit mode aliases pointer to two bytes
// R8: input byte write folds into result
// R9: result port reads or overwrites pointed byte
// R10: control write with auto enable starts scan
// R11: completion flag low during scan, resets high
// R12: processor stalled for whole scan duration
// R13: start sector times 512 is first address
// R14: software writes zero to reserved auto bit
// R15: 16-bit mode MSB-first with poly 0x1021
// R16: 32-bit mode reflected with poly 0xEDB88320
// R17: sector count sets number of sectors scanned
// R18: result holds until initialised, overwritten or fed
// R19: scan folds flash bytes in ascending order
module crc_engine (
    input  wire logic                 mclk,         // system clock
    input  wire logic                 nrst,         // async reset, low
    input  wire crc_pkg::crc_sfr_req_t sfr_req,     // register access
    output logic                [7:0] sfr_rdata,    // read data
    output logic                      cpu_stall,    // hold processor
    output logic                      flash_rd,     // flash read pulse
    output logic [crc_pkg::FADDR_W-1:0] flash_addr, // flash byte address
    input  wire logic                 flash_rvalid, // flash data valid
    input  wire logic           [7:0] flash_rdata   // flash data
);
    import crc_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // One byte through the selected algorithm
    function automatic logic [31:0] crc_fold(input logic [31:0] acc,
                                             input logic [7:0]  din,
                                             input logic        sel16);
        logic [31:0] a;
        a = acc;
        if (sel16) begin
            a[15:8] = a[15:8] ^ din;                       // R15
            for (int i = 0; i < 8; i++) begin
                a[15:0] = a[15] ? ({a[14:0], 1'b0} ^ POLY16)
                                : {a[14:0], 1'b0};       // R15
            end
        end else begin
            a[7:0] = a[7:0] ^ din;                         // R16
            for (int i = 0; i < 8; i++) begin
                a = a[0] ? ({1'b0, a[31:1]} ^ POLY32_REFL)
                         : {1'b0, a[31:1]};              // R16
            end
        end
        return a;
    endfunction

    // Byte lane chosen by the pointer, aliased in 16-bit mode
    function automatic logic [1:0] lane_of(input logic [1:0] pnt,
                                           input logic       sel16);
        return sel16 ? {1'b0, pnt[0]} : pnt;               // R6 R7
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]        result_reg;       // internal CRC result
    logic               poly_sel_reg;     // polynomial_select
    logic               val_sel_reg;      // set_value_select
    logic [1:0]         pnt_reg;          // result_byte_pointer
    logic [7:0]         input_reg;        // last input byte
    logic               auto_en_reg;      // automatic_enable
    logic [ST_W-1:0]    start_reg;        // start_sector
    logic [CNT_W-1:0]   count_reg;        // sector_count
    logic               cpt_reg;          // completion_flag
    crc_scan_t          scan_reg;         // fetch state
    logic [FADDR_W-1:0] addr_reg;         // next fetch address
    logic [FADDR_W-1:0] end_reg;          // exclusive end address

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    logic wr_ctl;                         // control write
    logic wr_in;                          // input byte write
    logic wr_auto;                        // auto control write
    logic wr_cnt;                         // count write
    logic wr_res;                         // result port write
    logic rd_res;                         // result port read
    logic [1:0] lane;                     // active result byte

    assign wr_ctl  = sfr_req.wr && (sfr_req.addr == CRC_CONTROL_ADDR);
    assign wr_in   = sfr_req.wr && (sfr_req.addr == CRC_BYTE_INPUT_ADDR);
    assign wr_auto = sfr_req.wr && (sfr_req.addr == CRC_AUTO_CTRL_ADDR);
    assign wr_cnt  = sfr_req.wr && (sfr_req.addr == CRC_SECTOR_CNT_ADDR);
    assign wr_res  = sfr_req.wr && (sfr_req.addr == CRC_RESULT_ADDR);
    assign rd_res  = sfr_req.rd && (sfr_req.addr == CRC_RESULT_ADDR);
    assign lane    = lane_of(pnt_reg, poly_sel_reg);

    // ------------------------------------------------------------
    // Fetch FIFO
    // ------------------------------------------------------------
    logic       fifo_in_ready;            // room for a flash byte
    logic       fifo_out_valid;           // byte waiting to fold
    logic [7:0] fifo_out_data;            // byte to fold
    logic       scan_busy;                // scan in progress

    assign scan_busy = (scan_reg != SCAN_IDLE);

    // Bytes land in arrival order, so folding stays ascending
    crc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (flash_rvalid && scan_reg == SCAN_WAIT),
        .in_ready  (fifo_in_ready),
        .in_data   (flash_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (scan_busy),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------

    // Init bit is not stored: it acts and reads back zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            poly_sel_reg <= CTL_RESET[CTL_SEL_BIT];
            val_sel_reg  <= CTL_RESET[CTL_VAL_BIT];
            pnt_reg      <= CTL_RESET[1:0];
        end else if (wr_ctl) begin
            poly_sel_reg <= sfr_req.wdata[CTL_SEL_BIT];   // R2
            val_sel_reg  <= sfr_req.wdata[CTL_VAL_BIT];   // R4
            pnt_reg      <= sfr_req.wdata[1:0];           // R1
        end else if (wr_res || rd_res) begin
            pnt_reg <= pnt_reg + 2'h1;                   // R5
        end
    end

    // ------------------------------------------------------------
    // Input, auto control and count registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            input_reg   <= 8'h00;
            auto_en_reg <= 1'b0;
            start_reg   <= '0;
            count_reg   <= '0;
        end else begin
            if (wr_in) begin
                input_reg <= sfr_req.wdata;
            end
            // Reserved bit is dropped; software keeps it zero  R14
            if (wr_auto) begin
                auto_en_reg <= sfr_req.wdata[AUTO_EN_BIT];
                start_reg   <= sfr_req.wdata[ST_W-1:0];      // R13
            end
            if (wr_cnt) begin
                count_reg <= sfr_req.wdata[CNT_W-1:0];       // R17
            end
        end
    end

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------

    // Changes only on init, port write, input byte or scan byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            result_reg <= SEED_ZEROS;
        end else if (scan_busy && fifo_out_valid) begin
            result_reg <= crc_fold(result_reg, fifo_out_data,
                                   poly_sel_reg);           // R19
        end else if (wr_ctl && sfr_req.wdata[CTL_INIT_BIT]) begin
            // Seed chosen by the value written in the same cycle
            result_reg <= sfr_req.wdata[CTL_VAL_BIT] ? SEED_ONES
                                                     : SEED_ZEROS; // R3 R4
        end else if (wr_in) begin
            result_reg <= crc_fold(result_reg, sfr_req.wdata,
                                   poly_sel_reg);           // R8
        end else if (wr_res) begin
            result_reg[lane*8 +: 8] <= sfr_req.wdata;       // R9
        end else begin
            result_reg <= result_reg;                       // R18
        end
    end

    // ------------------------------------------------------------
    // Automatic scan sequencer
    // ------------------------------------------------------------

    // One read in flight at a time; a full FIFO holds off requests
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scan_reg <= SCAN_IDLE;
            addr_reg <= '0;
            end_reg  <= '0;
            cpt_reg  <= CPT_RESET;                          // R11
        end else begin
            case (scan_reg)
                SCAN_IDLE: begin
                    if (wr_ctl && auto_en_reg) begin        // R10
                        addr_reg <= FADDR_W'(start_reg) << SECTOR_SHIFT; // R13
                        end_reg  <= (FADDR_W'(start_reg) + FADDR_W'(count_reg))
                                    << SECTOR_SHIFT;        // R17
                        cpt_reg  <= 1'b0;                   // R11
                        scan_reg <= (count_reg == '0) ? SCAN_TAIL
                                                      : SCAN_REQ;
                    end
                end
                SCAN_REQ: begin
                    if (fifo_in_ready) begin
                        scan_reg <= SCAN_WAIT;
                    end
                end
                SCAN_WAIT: begin
                    if (flash_rvalid) begin
                        addr_reg <= addr_reg + 1'b1;        // R19
                        scan_reg <= (addr_reg + 1'b1 == end_reg) ? SCAN_TAIL
                                                                 : SCAN_REQ;
                    end
                end
                SCAN_TAIL: begin
                    // Wait for the last queued bytes to fold
                    if (!fifo_out_valid) begin
                        cpt_reg  <= 1'b1;                   // R11
                        scan_reg <= SCAN_IDLE;
                    end
                end
                default: begin
                    scan_reg <= SCAN_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cpu_stall  = scan_busy;                          // R12
    assign flash_rd   = (scan_reg == SCAN_REQ) && fifo_in_ready;
    assign flash_addr = addr_reg;

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                CRC_CONTROL_ADDR:
                    sfr_rdata <= {3'h0, poly_sel_reg, 1'b0,
                                  val_sel_reg, pnt_reg};    // R1
                CRC_BYTE_INPUT_ADDR:
                    sfr_rdata <= input_reg;
                CRC_AUTO_CTRL_ADDR:
                    sfr_rdata <= {auto_en_reg, cpt_reg, 1'b0, start_reg};
                CRC_SECTOR_CNT_ADDR:
                    sfr_rdata <= {2'h0, count_reg};
                CRC_RESULT_ADDR:
                    sfr_rdata <= result_reg[lane*8 +: 8];   // R9
                default:
                    sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// ### verification/crc_engine_chk.sv
/* Port checker for crc_engine: register reads and the flash scan link.
   Assumes it is bound to crc_engine and sees only its ports. */
`timescale 1ns/1ps
module crc_engine_chk (
    input wire logic                    mclk,         // system clock
    input wire logic                    nrst,         // async reset, low
    input wire crc_pkg::crc_sfr_req_t   sfr_req,      // register access
    input wire logic [7:0]              sfr_rdata,    // read data
    input wire logic                    cpu_stall,    // processor hold
    input wire logic                    flash_rd,     // fetch pulse
    input wire logic [crc_pkg::FADDR_W-1:0] flash_addr, // fetch address
    input wire logic                    flash_rvalid, // fetch answer
    input wire logic [7:0]              flash_rdata   // fetched byte
);
    import crc_pkg::*;
    // ------------------------------------------------------------
    // Shadow copies of the auto settings, taken from bus writes
    // ------------------------------------------------------------
    logic        auto_q; // auto enable
    logic [4:0]  st_q;   // start sector
    logic [5:0]  cnt_q;  // sector count
    logic [15:0] nreq_q; // fetches this scan
    logic [16:0] last_q; // last fetch address
    logic        seen_q; // a fetch seen this scan
    wire wr_ctl = sfr_req.wr && sfr_req.addr == CRC_CONTROL_ADDR;
    wire go     = wr_ctl && auto_q && !cpu_stall;
    // Auto control and count copies
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            auto_q <= 1'b0;
            st_q   <= 5'h00;
            cnt_q  <= 6'h00;
        end else if (sfr_req.wr && sfr_req.addr == CRC_AUTO_CTRL_ADDR) begin
            auto_q <= sfr_req.wdata[AUTO_EN_BIT];
            st_q   <= sfr_req.wdata[4:0];
        end else if (sfr_req.wr && sfr_req.addr == CRC_SECTOR_CNT_ADDR) begin
            cnt_q <= sfr_req.wdata[5:0];
        end
    end
    // Fetch tally, cleared whenever the processor runs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nreq_q <= 16'h0000;
            seen_q <= 1'b0;
            last_q <= 17'h00000;
        end else if (!cpu_stall) begin
            nreq_q <= 16'h0000;
            seen_q <= 1'b0;
        end else if (flash_rd) begin
            nreq_q <= nreq_q + 16'h0001;
            seen_q <= 1'b1;
            last_q <= flash_addr;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_start; go |=> cpu_stall; endproperty
    property p_first; go && cnt_q != 6'h00 |=>
        flash_rd && flash_addr == 17'({st_q, 9'h000}); endproperty
    property p_step; flash_rd && seen_q |-> flash_addr == last_q + 17'h1;
    endproperty
    property p_one; flash_rd |=> !flash_rd until_with flash_rvalid;
    endproperty
    property p_hold; flash_rd |=> $stable(flash_addr) until_with flash_rvalid;
    endproperty
    property p_len; $fell(cpu_stall) |-> nreq_q == 16'({cnt_q, 9'h000});
    endproperty
    property p_cpt; sfr_req.rd && sfr_req.addr == CRC_AUTO_CTRL_ADDR &&
        !cpu_stall |=> sfr_rdata[AUTO_CPT_BIT]; endproperty
    property p_ctl; sfr_req.rd && sfr_req.addr == CRC_CONTROL_ADDR |=>
        sfr_rdata[7:5] == 3'h0 && !sfr_rdata[CTL_INIT_BIT]; endproperty
    property p_cnt; sfr_req.rd && sfr_req.addr == CRC_SECTOR_CNT_ADDR |=>
        sfr_rdata[7:6] == 2'h0; endproperty
    property p_idle; !cpu_stall |-> !flash_rd; endproperty
    a_start: assert property (p_start)
        else $error("no stall after start");
    a_first: assert property (p_first)
        else $error("first fetch address wrong");
    a_step: assert property (p_step)
        else $error("fetch address not ascending");
    a_one: assert property (p_one)
        else $error("second fetch before answer");
    a_hold: assert property (p_hold)
        else $error("fetch address moved");
    a_len: assert property (p_len)
        else $error("scan fetched wrong byte count");
    a_cpt: assert property (p_cpt)
        else $error("completion flag low");
    a_ctl: assert property (p_ctl)
        else $error("control unused bits not zero");
    a_cnt: assert property (p_cnt)
        else $error("count unused bits not zero");
    a_idle: assert property (p_idle)
        else $error("fetch while processor runs");
    c_go: cover property (go);
    c_done: cover property ($fell(cpu_stall));
    c_res: cover property (sfr_req.rd && sfr_req.addr == CRC_RESULT_ADDR);
endmodule

// ### verification/crc_engine_tb.sv
/* Self-checking testbench for crc_engine.
   Drives the register bus and answers flash fetches itself. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
 err_total++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module crc_engine_tb;
    import crc_pkg::*;
    logic               mclk, nrst, cpu_stall, flash_rd, flash_rvalid;
    crc_sfr_req_t       sfr_req;      // bus request
    logic [7:0]         sfr_rdata, flash_rdata, q, b;
    logic [FADDR_W-1:0] flash_addr;   // fetch address
    logic [16:0]        fl_addr;      // address in flight
    logic [31:0]        m, t;         // expected result
    logic [4:0]         st;           // start sector
    logic [5:0]         cn;           // sector count
    int seed = 94, err_total, samples_checked, fl_wait;
    logic [7:0] ra [6] = '{8'h91, 8'h94, 8'h96, 8'h97, 8'hd9, 8'h95};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    crc_engine i_dut (.mclk(mclk), .nrst(nrst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .flash_rvalid(flash_rvalid),
        .flash_rdata(flash_rdata));
    // ------------------------------------------------------------
    // Clock, reference model, flash answerer
    // ------------------------------------------------------------
    always #50 mclk = ~mclk;
    // One byte folded into the running result
    function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d,
                                         logic s16);
        if (s16) begin
            c[15:8] = c[15:8] ^ d;
            for (int i = 0; i < 8; i++) begin
                c[15:0] = c[15] ? (c[15:0] << 1) ^ POLY16 : c[15:0] << 1;
            end
        end else begin
            c[7:0] = c[7:0] ^ d;
            for (int i = 0; i < 8; i++) begin
                c = c[0] ? (c >> 1) ^ POLY32_REFL : c >> 1;
            end
        end
        return c;
    endfunction
    // Flash contents as a function of address
    function automatic logic [7:0] fbyte(logic [16:0] a);
        return a[7:0] ^ a[15:8] ^ {a[16], 7'h2b};
    endfunction
    // Latency 1..4 by address; junk data when idle
    always @(posedge mclk) begin
        flash_rvalid <= 1'b0;
        flash_rdata  <= ~flash_rdata;
        if (fl_wait == 1) begin
            flash_rvalid <= 1'b1;
            flash_rdata  <= fbyte(fl_addr);
        end
        if (fl_wait > 0) begin
            fl_wait <= fl_wait - 1;
        end else if (flash_rd === 1'b1) begin
            fl_addr <= flash_addr;
            fl_wait <= 1 + int'(flash_addr[1:0]);
        end
    end
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, d,
                       output logic [7:0] r);
        @(posedge mclk);
        sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        sfr_req <= '0;
        @(negedge mclk);
        r = sfr_rdata;
    endtask
    // Read all four pointer slots from pointer zero
    task automatic chk_res(input logic s16, input logic [31:0] e);
        logic [7:0] r;
        bus(1'b1, CRC_CONTROL_ADDR, {3'h0, s16, 4'h0}, r);
        `CHK(cpu_stall, 1'b0)
        for (int p = 0; p < 4; p++) begin
            bus(1'b0, CRC_RESULT_ADDR, 8'h00, r);
            `CHK(r, e[8*(s16 ? p%2 : p)+:8])
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bounded wait for the scan to finish
    task automatic wait_idle();
        for (int n = 0; cpu_stall !== 1'b0; n++) begin
            if (n == 20000) begin
                err_total++;
                test_done();
            end
            @(posedge mclk);
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        sfr_req = '0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ra[i], 8'h00, q);
            `CHK(q, rv[i])
        end
        $display("test reset values done");
        bus(1'b1, CRC_CONTROL_ADDR, 8'hff, q);
        bus(1'b0, CRC_CONTROL_ADDR, 8'h00, q);
        `CHK(q, 8'h17)
        chk_res(1'b1, SEED_ONES);
        t = fold(SEED_ONES, 8'h63, 1'b1);
        `CHK(t[15:0], 16'hbd35)
        t = fold(SEED_ONES, 8'h63, 1'b0);
        `CHK(t, 32'hf9462090)
        $display("test control done");
        for (int md = 0; md < 4; md++) begin
            bus(1'b1, CRC_CONTROL_ADDR, {3'h0, md[1], 1'b1, md[0], 2'h0}, q);
            m = md[0] ? SEED_ONES : SEED_ZEROS;
            for (int k = $random(seed) & 7; k >= 0; k--) begin
                b = 8'($random(seed));
                bus(1'b1, CRC_BYTE_INPUT_ADDR, b, q);
                m = fold(m, b, md[1]);
            end
            bus(1'b0, CRC_BYTE_INPUT_ADDR, 8'h00, q);
            `CHK(q, b)
            chk_res(md[1], m);
        end
        $display("test byte feed done");
        bus(1'b1, CRC_CONTROL_ADDR, 8'h02, q);
        b = 8'($random(seed));
        bus(1'b1, CRC_RESULT_ADDR, b, q);
        bus(1'b1, CRC_RESULT_ADDR, ~b, q);
        m[31:16] = {~b, b};
        chk_res(1'b0, m);
        $display("test result port done");
        for (int s = 0; s < 3; s++) begin
            st = (s == 0) ? 5'd31 : 5'($random(seed));
            cn = (s == 2) ? 6'd0 : 6'(s + 1);
            bus(1'b1, CRC_AUTO_CTRL_ADDR, {3'b100, st}, q);
            bus(1'b1, CRC_SECTOR_CNT_ADDR, {2'b00, cn}, q);
            bus(1'b1, CRC_CONTROL_ADDR, 8'h0c, q);
            `CHK(cpu_stall, 1'b1)
            m = SEED_ONES;
            for (int a = st * 512; a < (st + cn) * 512; a++) begin
                m = fold(m, fbyte(17'(a)), 1'b0);
            end
            wait_idle();
            bus(1'b0, CRC_AUTO_CTRL_ADDR, 8'h00, q);
            `CHK(q, {3'b110, st})
            bus(1'b1, CRC_AUTO_CTRL_ADDR, {3'b000, st}, q);
            chk_res(1'b0, m);
        end
        $display("test flash scan done");
        test_done();
    end
endmodule
bind crc_engine crc_engine_chk i_chk (.mclk(mclk), .nrst(nrst),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
    .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rvalid(flash_rvalid), .flash_rdata(flash_rdata));
